// *** hw/ee_guard_pkg.sv ***
// Purpose: Shared constants for the data EEPROM write guard
// Assumes: 100 MHz core clock, AXI4-Lite register access
// Notes:   Byte addresses are four times the register index
package ee_guard_pkg;
  // Register indices, byte address is index times four
  localparam logic [7:0] IDX_DATA     = 8'h08;
  localparam logic [7:0] IDX_ADDR     = 8'h09;
  localparam logic [7:0] IDX_CTRL     = 8'h88;
  localparam logic [7:0] IDX_UNLOCK   = 8'h89;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
  localparam logic [7:0] IDX_CONFIG   = 8'h92;
  // Control register field positions
  localparam int BIT_RD    = 0;
  localparam int BIT_WR    = 1;
  localparam int BIT_PERM  = 2;
  localparam int BIT_ABORT = 3;
  localparam int BIT_DONE  = 4;
  // Interrupt status field positions
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ABORT = 1;
  // Config read-back positions
  localparam int CFG_DP = 0;
  localparam int CFG_CP = 1;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [1:0] RST_IRQ   = 2'h0;
  // Power-up delay and EEPROM write time
  localparam int CLK_MHZ         = 100;
  localparam int POWER_UP_MS     = 72;
  localparam int POWER_UP_CYCLES = POWER_UP_MS * 1000 * CLK_MHZ;
  localparam int WRITE_US        = 4;
  localparam int WRITE_CYCLES    = WRITE_US * CLK_MHZ;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Array geometry
  localparam int ADDR_W = 6;
  localparam int DEPTH  = 64;
  // Sequencer states
  typedef enum logic [1:0] {IDLE, WRITING} wr_state_t;
  typedef enum logic [1:0] {UNL_NONE, UNL_ONE, UNL_TWO} unl_state_t;
endpackage

// *** hw/ee_array.sv ***
// Purpose: Data EEPROM cell array, 64 bytes
// Assumes: Single clock, registered read data
// Notes:   Contents survive rst, as non-volatile cells would
`timescale 1ns/10ps
`default_nettype none
module ee_array (
  // Clock
  input  wire logic       clock,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read port
  input  wire logic [5:0] rd_addr,
  output var  logic [7:0] rd_data
);
  // Cell storage
  logic [7:0] cells [0:63];

  // Write and registered read
  always_ff @(posedge clock) begin
    if (wr_en) begin
      cells[wr_addr] <= wr_data;
    end
    rd_data <= cells[rd_addr];
  end
endmodule // ee_array
`default_nettype wire

// *** hw/ee_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level input
// Notes:   Output changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module ee_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Level in and out
  input  wire logic async_in,
  output var  logic sync_out
);
  logic s1_reg, s2_reg, s3_reg;  // Synchroniser stages
  logic out_next;                // Filtered next value

  // Accept a change only when later stages agree
  always_comb begin
    out_next = (s2_reg == s3_reg) ? s3_reg : sync_out;
  end

  // Register stages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1_reg   <= async_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= out_next;
    end
  end
endmodule // ee_sync
`default_nettype wire

// *** hw/ee_guard.sv ***
// Purpose: Data EEPROM access and write guard behind AXI4-Lite
// Assumes: One clock at 100 MHz, power-on reset on rst
// Notes:   Warm resets come in as pins and are synchronised
//
// Functional notes
// - Power-up clears the write permit bit
// - No write while power-up delay runs
// - Write needs permit plus completed unlock
// - Protected data stays readable and writable plain
// - Separate program and data protection settings
// - Config bits read zero when programmed
// - Write-go ignored without permit or unlock, during the power-up delay or mid-write; latched otherwise
// - Completion clears write-go, sets done flag
// - Warm reset mid-write sets abort flag
`timescale 1ns/10ps
`default_nettype none
module ee_guard
  import ee_guard_pkg::*;
#(
  parameter int POWER_UP_CNT = POWER_UP_CYCLES  // Power-up delay in cycles
) (
  // Clock and power-on reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Warm reset requests from pins
  input  wire logic        external_reset_pin_n,
  input  wire logic        watchdog_reset,
  // Configuration straps, 0 means programmed
  input  wire logic        program_protect,
  input  wire logic        data_protect,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt
  output var  logic        irq
);
  // Maps an index to its byte address
  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

  // Warm reset sync outputs and event
  logic ext_rst_s, wdt_s;  // Synchronised warm reset pins
  logic warm_rst;          // Either warm reset active
  // Held address and data words
  logic [11:0] aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0]  ws_reg, ws_next;
  logic        aw_ok_reg, aw_ok_next, wd_ok_reg, wd_ok_next;
  logic        bvalid_next, rvalid_next;
  logic [1:0]  bresp_next, rresp_next;
  logic [31:0] rdata_next;
  // Registers
  logic [7:0]  data_reg, data_next;
  logic [7:0]  addr_reg, addr_next;
  logic        perm_reg, perm_next;
  logic        go_reg, go_next;
  logic        done_reg, done_next;
  logic        abort_reg, abort_next;
  logic [1:0]  mask_reg, mask_next;
  logic        rd_pend_reg, rd_pend_next;
  // Unlock tracker and sequencer
  unl_state_t  unl_reg, unl_next;
  wr_state_t   st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [31:0] pwr_reg, pwr_next;
  // Array port
  logic        arr_we;
  logic [7:0]  arr_q;
  // Decoded write
  logic        do_write;
  logic [7:0]  wbyte;

  // Warm reset pins through three stages
  ee_sync u_sync_ext (
    .clock    (clock),
    .rst      (rst),
    .async_in (~external_reset_pin_n),
    .sync_out (ext_rst_s)
  );
  ee_sync u_sync_wdt (
    .clock    (clock),
    .rst      (rst),
    .async_in (watchdog_reset),
    .sync_out (wdt_s)
  );
  assign warm_rst = ext_rst_s | wdt_s;

  // Data array; protection straps never gate access
  ee_array u_array (
    .clock   (clock),
    .wr_en   (arr_we),
    .wr_addr (addr_reg[ADDR_W-1:0]),
    .wr_data (data_reg),
    .rd_addr (addr_reg[ADDR_W-1:0]),
    .rd_data (arr_q)
  );

  // Bus handshakes, combinational
  assign s_axi_awready = ~aw_ok_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~wd_ok_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_ok_reg & wd_ok_reg & ~s_axi_bvalid;
  assign wbyte    = wd_reg[7:0];

  // Bus channel next values
  always_comb begin
    aw_next = aw_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    aw_ok_next = aw_ok_reg;
    wd_ok_next = wd_ok_reg;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = s_axi_awaddr;
      aw_ok_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
      wd_ok_next = 1'b1;
    end
    // Answer once both are held
    if (do_write) begin
      aw_ok_next = 1'b0;
      wd_ok_next = 1'b0;
      bvalid_next = 1'b1;
      case (aw_reg)
        byte_addr(IDX_DATA), byte_addr(IDX_ADDR), byte_addr(IDX_CTRL),
        byte_addr(IDX_UNLOCK), byte_addr(IDX_IRQ_STAT), byte_addr(IDX_IRQ_MASK),
        byte_addr(IDX_CONFIG): bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Reads answer one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      rdata_next = 32'h0000_0000;
      case (s_axi_araddr)
        byte_addr(IDX_DATA): rdata_next[7:0] = data_reg;
        byte_addr(IDX_ADDR): rdata_next[7:0] = addr_reg;
        byte_addr(IDX_CTRL): rdata_next[7:0] = {3'b000, done_reg, abort_reg, perm_reg, go_reg, 1'b0};
        byte_addr(IDX_UNLOCK): rdata_next[7:0] = 8'h00;
        byte_addr(IDX_IRQ_STAT): rdata_next[1:0] = {abort_reg, done_reg};
        byte_addr(IDX_IRQ_MASK): rdata_next[1:0] = mask_reg;
        // two straps read back raw, 0 = programmed
        byte_addr(IDX_CONFIG): rdata_next[1:0] = {program_protect, data_protect};
        default: rresp_next = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Register file and write guard next values
  always_comb begin
    data_next = data_reg;
    addr_next = addr_reg;
    perm_next = perm_reg;
    go_next = go_reg;
    done_next = done_reg;
    abort_next = abort_reg;
    mask_next = mask_reg;
    unl_next = unl_reg;
    rd_pend_next = 1'b0;
    st_next = st_reg;
    cnt_next = cnt_reg;
    pwr_next = pwr_reg;
    arr_we = 1'b0;
    // Power-up delay countdown
    if (pwr_reg != 32'h0000_0000) begin
      pwr_next = pwr_reg - 32'h0000_0001;
    end
    // Read result lands in the data register
    if (rd_pend_reg) begin
      data_next = arr_q;
    end
    // Software writes, low byte lane only
    if (do_write && ws_reg[0]) begin
      // Any register write except a correct unlock key breaks the sequence
      unl_next = UNL_NONE;
      case (aw_reg)
        byte_addr(IDX_DATA): begin
          data_next = wbyte;
        end
        byte_addr(IDX_ADDR): begin
          addr_next = wbyte;
        end
        byte_addr(IDX_UNLOCK): begin
          if (wbyte == KEY_FIRST) begin
            unl_next = UNL_ONE;
          end else if (wbyte == KEY_SECOND && unl_reg == UNL_ONE) begin
            unl_next = UNL_TWO;
          end
        end
        byte_addr(IDX_CTRL): begin
          perm_next = wbyte[BIT_PERM];
          // Flags clear by software writing zero
          if (!wbyte[BIT_DONE]) begin
            done_next = 1'b0;
          end
          if (!wbyte[BIT_ABORT]) begin
            abort_next = 1'b0;
          end
          // Read start, data arrives next cycle
          if (wbyte[BIT_RD] && st_reg == IDLE) begin
            rd_pend_next = 1'b1;
          end
          if (wbyte[BIT_WR] && perm_reg && unl_reg == UNL_TWO && st_reg == IDLE && !go_reg
              && pwr_reg == 32'h0000_0000) begin
            go_next = 1'b1;
            st_next = WRITING;
            cnt_next = 32'(WRITE_CYCLES);
          end
        end
        byte_addr(IDX_IRQ_STAT): begin
          if (wbyte[IRQ_DONE]) begin
            done_next = 1'b0;
          end
          if (wbyte[IRQ_ABORT]) begin
            abort_next = 1'b0;
          end
        end
        byte_addr(IDX_IRQ_MASK): begin
          mask_next = wbyte[1:0];
        end
        default: begin
          unl_next = UNL_NONE;
        end
      endcase
    end
    // Write sequencer; permit changes do not stop it
    case (st_reg)
      IDLE: begin
      end
      WRITING: begin
        if (cnt_reg == 32'h0000_0001) begin
          // finish clears go, sets done (set wins)
          arr_we = 1'b1;
          go_next = 1'b0;
          done_next = 1'b1;
          st_next = IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h0000_0001;
        end
      end
      default: begin
        st_next = IDLE;
      end
    endcase
    // warm reset aborts write, keeps data and address
    if (warm_rst) begin
      if (st_reg == WRITING) begin
        abort_next = 1'b1;
      end
      arr_we = 1'b0;
      go_next = 1'b0;
      st_next = IDLE;
      unl_next = UNL_NONE;
      rd_pend_next = 1'b0;
      data_next = data_reg;
      addr_next = addr_reg;
      done_next = done_reg;
    end
  end

  // Interrupt level from unmasked sticky bits
  assign irq = |({abort_reg, done_reg} & mask_reg);

  // Register all state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_reg <= 12'h000;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      aw_ok_reg <= 1'b0;
      wd_ok_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      data_reg <= RST_BYTE;
      addr_reg <= RST_BYTE;
      perm_reg <= 1'b0;
      go_reg <= 1'b0;
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
      mask_reg <= RST_IRQ;
      rd_pend_reg <= 1'b0;
      unl_reg <= UNL_NONE;
      st_reg <= IDLE;
      cnt_reg <= 32'h0000_0000;
      pwr_reg <= 32'(POWER_UP_CNT);
    end else begin
      aw_reg <= aw_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      aw_ok_reg <= aw_ok_next;
      wd_ok_reg <= wd_ok_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      perm_reg <= perm_next;
      go_reg <= go_next;
      done_reg <= done_next;
      abort_reg <= abort_next;
      mask_reg <= mask_next;
      rd_pend_reg <= rd_pend_next;
      unl_reg <= unl_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pwr_reg <= pwr_next;
    end
  end
endmodule // ee_guard
`default_nettype wire

// *** bench/ee_guard_monitor.sv ***
// Purpose: Port-level checks on the data EEPROM write guard
// Assumes: One clock, rst asynchronous and active high
// Notes:   Bound into every ee_guard instance
`timescale 1ns/10ps
`default_nettype none
module ee_guard_monitor
  import ee_guard_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Straps and interrupt
  input wire logic        program_protect,
  input wire logic        data_protect,
  input wire logic        irq,
  // Read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Byte addresses of the watched registers
  localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] A_UNL  = {2'b00, IDX_UNLOCK, 2'b00};
  localparam logic [11:0] A_CFG  = {2'b00, IDX_CONFIG, 2'b00};
  // Read address taken this cycle
  logic ar_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;

  AST_QUIET_AFTER_RST: assert property ($fell(rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("interrupt or answer active after reset");
  AST_READ_ANSWER: assert property (ar_go |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_WRITE_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_READ_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_CFG_READ: assert property (ar_go && s_axi_araddr == A_CFG
    |=> s_axi_rdata == {30'h0, $past(program_protect), $past(data_protect)})
    else $error("config read back wrong");
  AST_UNMAPPED: assert property (ar_go && s_axi_araddr[11:10] != 2'b00
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_UNLOCK_READ: assert property (ar_go && s_axi_araddr == A_UNL |=> s_axi_rdata == 32'h0)
    else $error("unlock port read not zero");
  AST_CTRL_UPPER: assert property (ar_go && s_axi_araddr == A_CTRL |=> s_axi_rdata[31:5] == 27'h0)
    else $error("control upper bits not zero");
endmodule // ee_guard_monitor

bind ee_guard ee_guard_monitor u_mon (.clock, .rst, .program_protect, .data_protect, .irq,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
`default_nettype wire

// *** bench/ee_core_model.sv ***
// Purpose: Processor core model, AXI4-Lite master for the guard
// Assumes: Signals change by non-blocking assignment after an edge
// Notes:   Released payload shows its inverse, never a stale value
`timescale 1ns/10ps
`default_nettype none
module ee_core_model
  import ee_guard_pkg::*;
(
  // Clock
  input  wire logic        clock,
  // Write channels
  output var  logic [11:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  // Read channels
  output var  logic [11:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
  end

  // One byte write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clock);
      if (!ad && s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!dd && s_axi_wready) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~{24'h0, d};
      end
    end
    while (!s_axi_bvalid) @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One word read
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic launch(input logic [7:0] ctrl);
    logic [1:0] r;
    wr({2'b00, IDX_UNLOCK, 2'b00}, KEY_FIRST, r);
    wr({2'b00, IDX_UNLOCK, 2'b00}, KEY_SECOND, r);
    wr({2'b00, IDX_CTRL, 2'b00}, ctrl, r);
  endtask
endmodule // ee_core_model
`default_nettype wire

// *** bench/data_eeprom_write_guard_tb.sv ***
// Purpose: Self-checking bench for the data EEPROM write guard
// Assumes: Power-up delay shortened to PUC cycles
// Notes:   Data protect strap held programmed until t_misc leaves it open
`timescale 1ns/10ps
`default_nettype none
module data_eeprom_write_guard_tb;
  import ee_guard_pkg::*;
  localparam int PUC = 60;  // Shortened power-up delay
  // Register byte addresses
  localparam logic [11:0] A_DATA = {2'b00, IDX_DATA, 2'b00};
  localparam logic [11:0] A_ADDR = {2'b00, IDX_ADDR, 2'b00};
  localparam logic [11:0] A_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] A_UNL  = {2'b00, IDX_UNLOCK, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_CFG  = {2'b00, IDX_CONFIG, 2'b00};
  // Clock, resets, straps
  logic clock = 1'b0, rst = 1'b1, external_reset_pin_n = 1'b1, watchdog_reset = 1'b0;
  logic program_protect = 1'b1, data_protect = 1'b0, irq;
  // Bus nets
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail = 0, n_checks = 0;

  always #5 clock = ~clock;

  ee_guard #(.POWER_UP_CNT(PUC)) u_dut (.clock, .rst, .external_reset_pin_n, .watchdog_reset,
    .program_protect, .data_protect, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq);
  ee_core_model u_core (.clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bus shorthands
  task automatic w(input logic [11:0] a, input logic [7:0] d);
    logic [1:0] r;
    u_core.wr(a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    u_core.rd(a, d, r);
    chk(d, e);
  endtask

  // Fresh part: permit clear, write refused while delay runs
  task automatic t_powerup();
    rdc(A_CTRL, 32'h00);
    w(A_CTRL, 8'h04);
    u_core.launch(8'h06);
    rdc(A_CTRL, 32'h04);
    repeat (WRITE_CYCLES + 20) @(posedge clock);
    rdc(A_CTRL, 32'h04);
  endtask

  // Good write, repeat go ignored, readback, interrupt
  task automatic t_write(input logic [7:0] a, input logic [7:0] d);
    w(A_ADDR, a);
    w(A_DATA, d);
    u_core.launch(8'h06);
    rdc(A_CTRL, 32'h06);
    u_core.launch(8'h02);
    rdc(A_CTRL, 32'h02);
    repeat (WRITE_CYCLES + 20) @(posedge clock);
    rdc(A_CTRL, 32'h10);
    w(A_MASK, 8'h01);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
    w(A_STAT, 8'h01);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    w(A_DATA, ~d);
    w(A_CTRL, 8'h01);
    rdc(A_DATA, {24'h0, d});
    rdc(A_CTRL, 32'h00);
  endtask

  // No permit, broken and reversed key order
  task automatic t_refuse();
    u_core.launch(8'h06);
    rdc(A_CTRL, 32'h04);
    w(A_UNL, KEY_FIRST);
    w(A_DATA, 8'h11);
    w(A_UNL, KEY_SECOND);
    w(A_CTRL, 8'h06);
    rdc(A_CTRL, 32'h04);
    w(A_UNL, KEY_SECOND);
    w(A_UNL, KEY_FIRST);
    w(A_CTRL, 8'h06);
    rdc(A_CTRL, 32'h04);
  endtask

  // Warm reset from each source during a write
  task automatic t_abort();
    logic [31:0] d;
    logic [1:0]  r;
    for (int s = 0; s < 2; s++) begin
      w(A_ADDR, 8'h07);
      w(A_DATA, 8'h3c);
      u_core.launch(8'h06);
      repeat (20) @(posedge clock);
      if (s == 0) external_reset_pin_n <= 1'b0;
      else watchdog_reset <= 1'b1;
      repeat (10) @(posedge clock);
      external_reset_pin_n <= 1'b1;
      watchdog_reset <= 1'b0;
      repeat (10) @(posedge clock);
      u_core.rd(A_CTRL, d, r);
      chk(d & 32'h1b, 32'h08);
      rdc(A_DATA, 32'h3c);
      rdc(A_ADDR, 32'h07);
      rdc(A_STAT, 32'h02);
      // Abort flag raises the interrupt once unmasked
      w(A_MASK, 8'h02);
      @(negedge clock);
      chk({31'h0, irq}, 32'h1);
      // Keep permit set for the next pass, clear both flags
      w(A_CTRL, 8'h04);
      w(A_STAT, 8'h03);
      @(negedge clock);
      chk({31'h0, irq}, 32'h0);
    end
  endtask

  // Straps, unlock readback, unmapped place
  task automatic t_misc();
    logic [31:0] d;
    logic [1:0]  r;
    rdc(A_CFG, 32'h2);
    rdc(A_UNL, 32'h0);
    // Swap the straps: program protected, data left open
    program_protect <= 1'b0;
    data_protect    <= 1'b1;
    rdc(A_CFG, 32'h1);
    u_core.rd(12'h400, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    u_core.wr(12'h400, 8'h5a, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_powerup();
    t_write(8'h05, 8'ha5);
    t_refuse();
    t_abort();
    t_misc();
    end_of_test();
  end

  // Watchdog on a hung run
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_of_test();
  end
endmodule // data_eeprom_write_guard_tb
`default_nettype wire
